// file: blob_encap_decap.v
// Blob encapsulation and decapsulation sequencer
// Notes on behaviour
// - Blob type code feeds key derivation
// - One format, content, state per blob
// - Normal blob: random key, CCM payload
// - Blob key wrapped ECB; MAC checks both
// - Normal wrapping key from master in trusted and secure states, never output
// - Test blob prepends plain keys; test key
// - Test format only in non-secure mode
// - Verification blob outputs distinct-derived key only
// - Data blobs: plaintext in and out
// - Key blob out: rewrapped or key register
// - Key blob in: unwrap session key first
// - Derivation distinct per content variant
// - Trusted and secure derivations differ
// - Non-secure derives from test key
// - Session keks refreshed randomly each power-up
// - Session keys stored wrapped, loaded unwrapped
// - Encap: context setup, key load, CCM
// - Wrapped key, ciphertext 32 past the sealed start, MAC last
// - Decap unwraps blob key first
// - Decap context setup, payload 32 past the sealed start
// - Encap order: RNG, encrypt, derive, wrap
// - Wrapping key is hash of fields
// - Nonce and counter fixed constants
`timescale 1ns/1ps
`default_nettype none
`include "blob_engine_defs.vh"

module blob_encap_decap #(
    parameter MOD_W = 128
) (
    // Clock and reset
    input  wire              core_clk_i,
    input  wire              rst_n_i,
    // Job request
    input  wire              job_valid_i,
    output wire              job_ready_o,
    input  wire              job_decap_i,
    input  wire [1:0]        job_format_i,
    input  wire [2:0]        job_content_i,
    input  wire              job_to_key_reg_i,
    input  wire [MOD_W-1:0]  job_modifier_i,
    input  wire [1:0]        sec_state_i,
    input  wire [31:0]       job_len_i,
    // Job completion
    output reg               done_o,
    output reg  [3:0]        status_o,
    // Random number generator
    output reg               rng_req_o,
    input  wire              rng_ack_i,
    input  wire [255:0]      rng_data_i,
    // Key derivation hash unit
    output reg               kdf_req_o,
    output reg               kdf_src_o,
    output reg  [MOD_W+4:0]  kdf_msg_o,
    input  wire              kdf_ack_i,
    input  wire [255:0]      kdf_digest_i,
    // Class-1 cipher unit
    output reg               aes_req_o,
    output reg  [1:0]        aes_mode_o,
    output reg               aes_dec_o,
    output reg  [255:0]      aes_key_o,
    output reg  [127:0]      ctx_first_block_o,
    output reg  [127:0]      ctx_initial_counter_o,
    output reg  [31:0]       aes_offset_o,
    output reg  [31:0]       aes_len_o,
    input  wire              aes_ack_i,
    input  wire              aes_mac_ok_i,
    input  wire [255:0]      aes_result_i,
    // Memory writer for plain key fields
    output reg               wr_req_o,
    output reg  [31:0]       wr_offset_o,
    output reg  [255:0]      wr_data_o,
    input  wire              wr_ack_i,
    // Internal key register load
    output reg               key_load_o,
    output reg  [255:0]      key_load_data_o
);

    // States
    localparam S_IDLE   = 4'h0;
    localparam S_RNG    = 4'h1;
    localparam S_KEKIN  = 4'h2;
    localparam S_PAYLD  = 4'h3;
    localparam S_KDF    = 4'h4;
    localparam S_WRAP   = 4'h5;
    localparam S_TESTWR = 4'h6;
    localparam S_UNWRAP = 4'h7;
    localparam S_REWRAP = 4'h8;
    localparam S_DONE   = 4'h9;

    reg [3:0]       state;
    reg             decap;
    reg [1:0]       fmt;
    reg [2:0]       content;
    reg             to_key_reg;
    reg [1:0]       sst;
    reg [31:0]      len;
    reg [MOD_W-1:0] modifier;
    reg [255:0]     blob_key;
    reg [255:0]     wrap_key;
    reg [1:0]       test_step;

    // Valid combination of the three categories
    function type_ok;
        input [1:0] f;
        input [2:0] c;
        input [1:0] s;
        begin
            type_ok = (f <= `FMT_MKV) && (s <= `SST_NONSECURE)
                      && (c == `CNT_DATA || c[2]);
        end
    endfunction

    // Type identifier hashed into the wrapping key; the verification
    // format takes a code that no accepted content uses, so its key
    // never equals a data or key blob one
    function [2:0] type_code;
        input [1:0] f;
        input [2:0] c;
        begin
            type_code = (f == `FMT_MKV) ? 3'h1 : c;
        end
    endfunction

    // Start of the sealed part; a test blob has both plain keys ahead
    function [31:0] blob_base;
        input [1:0] f;
        begin
            blob_base = (f == `FMT_TEST) ? {16'h0, `KEY_BYTES_2} : 32'h0;
        end
    endfunction

    assign job_ready_o = (state == S_IDLE);

    // Job sequencer
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state                 <= S_IDLE;
            decap                 <= 1'b0;
            fmt                   <= 2'h0;
            content               <= 3'h0;
            to_key_reg            <= 1'b0;
            sst                   <= 2'h0;
            len                   <= 32'h0;
            modifier              <= {MOD_W{1'b0}};
            blob_key              <= 256'h0;
            wrap_key              <= 256'h0;
            test_step             <= 2'h0;
            done_o                <= 1'b0;
            status_o              <= 4'h0;
            rng_req_o             <= 1'b0;
            kdf_req_o             <= 1'b0;
            kdf_src_o             <= 1'b0;
            kdf_msg_o             <= {(MOD_W+5){1'b0}};
            aes_req_o             <= 1'b0;
            aes_mode_o            <= 2'h0;
            aes_dec_o             <= 1'b0;
            aes_key_o             <= 256'h0;
            ctx_first_block_o     <= 128'h0;
            ctx_initial_counter_o <= 128'h0;
            aes_offset_o          <= 32'h0;
            aes_len_o             <= 32'h0;
            wr_req_o              <= 1'b0;
            wr_offset_o           <= 32'h0;
            wr_data_o             <= 256'h0;
            key_load_o            <= 1'b0;
            key_load_data_o       <= 256'h0;
        end else begin
            done_o     <= 1'b0;
            key_load_o <= 1'b0;
            case (state)
            S_IDLE: begin
                if (job_valid_i) begin
                    decap      <= job_decap_i;
                    fmt        <= job_format_i;
                    content    <= job_content_i;
                    to_key_reg <= job_to_key_reg_i;
                    sst        <= sec_state_i;
                    len        <= job_len_i;
                    modifier   <= job_modifier_i;
                    status_o   <= `ST_OK;
                    test_step  <= 2'h0;
                    if (!type_ok(job_format_i, job_content_i,
                                 sec_state_i)) begin
                        status_o <= `ST_BAD_TYPE;
                        state    <= S_DONE;
                    end else if (job_format_i == `FMT_TEST &&
                            sec_state_i != `SST_NONSECURE) begin
                        // No request is raised, so nothing is written
                        status_o <= `ST_BAD_FORMAT;
                        state    <= S_DONE;
                    end else if (job_decap_i ||
                                 job_format_i == `FMT_MKV) begin
                        state <= S_KDF;
                    end else begin
                        rng_req_o <= 1'b1;
                        state     <= S_RNG;
                    end
                end
            end
            S_RNG: begin
                if (rng_ack_i) begin
                    rng_req_o <= 1'b0;
                    blob_key  <= rng_data_i;
                    if (content[2]) begin
                        // Session key is unwrapped and kept inside
                        aes_req_o  <= 1'b1;
                        aes_mode_o <= content[0] ? `MODE_CCM : `MODE_ECB;
                        aes_dec_o  <= 1'b1;
                        state      <= S_KEKIN;
                    end else begin
                        state <= S_PAYLD;
                    end
                end
            end
            S_KEKIN: begin
                // The unit picks the job or trusted session kek
                if (aes_ack_i) begin
                    aes_req_o <= 1'b0;
                    if (content[0] && !aes_mac_ok_i) begin
                        status_o <= `ST_MAC_FAIL;
                        state    <= S_DONE;
                    end else begin
                        key_load_data_o <= aes_result_i;
                        state           <= S_PAYLD;
                    end
                end
            end
            S_PAYLD: begin
                // Encrypt payload under the fresh blob key
                if (!aes_req_o) begin
                    aes_req_o             <= 1'b1;
                    aes_mode_o            <= `MODE_CCM;
                    aes_dec_o             <= 1'b0;
                    aes_key_o             <= blob_key;
                    ctx_first_block_o     <= `CCM_FIRST_BLOCK;
                    ctx_initial_counter_o <= `CCM_INITIAL_COUNTER;
                    aes_offset_o          <= blob_base(fmt) +
                                             {16'h0, `WRAPPED_KEY_LEN};
                    aes_len_o             <= len;
                end else if (aes_ack_i) begin
                    aes_req_o <= 1'b0;
                    state     <= S_KDF;
                end
            end
            S_KDF: begin
                // Digest of key, modifier, type and state
                if (!kdf_req_o) begin
                    kdf_req_o <= 1'b1;
                    kdf_src_o <= (sst == `SST_NONSECURE) ?
                                 `KSRC_TEST : `KSRC_MASTER;
                    kdf_msg_o <= {modifier, type_code(fmt, content),
                                  sst};
                end else if (kdf_ack_i) begin
                    kdf_req_o <= 1'b0;
                    wrap_key  <= kdf_digest_i;
                    if (fmt == `FMT_MKV) begin
                        // The verification format exposes it here; the test format writes it after the wrap
                        wr_req_o    <= 1'b1;
                        wr_offset_o <= 32'h0;
                        wr_data_o   <= kdf_digest_i;
                        test_step   <= 2'h2;
                        state       <= S_TESTWR;
                    end else if (decap) begin
                        aes_req_o    <= 1'b1;
                        aes_mode_o   <= `MODE_ECB;
                        aes_dec_o    <= 1'b1;
                        aes_key_o    <= kdf_digest_i;
                        aes_offset_o <= blob_base(fmt);
                        state        <= S_UNWRAP;
                    end else begin
                        aes_req_o    <= 1'b1;
                        aes_mode_o   <= `MODE_ECB;
                        aes_dec_o    <= 1'b0;
                        aes_key_o    <= kdf_digest_i;
                        aes_offset_o <= blob_base(fmt);
                        state        <= S_WRAP;
                    end
                end
            end
            S_WRAP: begin
                if (aes_ack_i) begin
                    aes_req_o <= 1'b0;
                    aes_key_o <= 256'h0;
                    if (fmt == `FMT_TEST) begin
                        // Plain wrapping key, then plain blob key
                        wr_req_o    <= 1'b1;
                        wr_offset_o <= 32'h0;
                        wr_data_o   <= wrap_key;
                        state       <= S_TESTWR;
                    end else begin
                        state <= S_DONE;
                    end
                end
            end
            S_TESTWR: begin
                if (wr_ack_i) begin
                    if (test_step == 2'h0) begin
                        wr_offset_o <= {16'h0, `WRAPPED_KEY_LEN};
                        wr_data_o   <= blob_key;
                        test_step   <= 2'h1;
                    end else begin
                        wr_req_o  <= 1'b0;
                        wr_data_o <= 256'h0;
                        state     <= S_DONE;
                    end
                end
            end
            S_UNWRAP: begin
                if (aes_ack_i) begin
                    aes_req_o             <= 1'b1;
                    aes_mode_o            <= `MODE_CCM;
                    aes_dec_o             <= 1'b1;
                    aes_key_o             <= aes_result_i;
                    blob_key              <= aes_result_i;
                    ctx_initial_counter_o <= `CCM_INITIAL_COUNTER;
                    ctx_first_block_o     <= `CCM_FIRST_BLOCK;
                    aes_offset_o          <= blob_base(fmt) +
                                             {16'h0, `WRAPPED_KEY_LEN};
                    aes_len_o             <= len;
                    state                 <= S_REWRAP;
                end else begin
                    aes_req_o <= 1'b1;
                end
            end
            S_REWRAP: begin
                // Key blobs never land in memory as plaintext; the
                // unit rewraps unless the key register is chosen
                if (aes_ack_i) begin
                    aes_req_o <= 1'b0;
                    aes_key_o <= 256'h0;
                    if (!aes_mac_ok_i) begin
                        status_o <= `ST_MAC_FAIL;
                    end else if (content[2] && to_key_reg) begin
                        key_load_o      <= 1'b1;
                        key_load_data_o <= aes_result_i;
                    end
                    state <= S_DONE;
                end
            end
            S_DONE: begin
                done_o   <= 1'b1;
                blob_key <= 256'h0;
                wrap_key <= 256'h0;
                state    <= S_IDLE;
            end
            default: begin
                state <= S_IDLE;
            end
            endcase
        end
    end

endmodule // blob_encap_decap

`default_nettype wire

// file: blob_engine_defs.vh
// Constants for the blob encapsulation and decapsulation sequencer
`ifndef BLOB_ENGINE_DEFS_VH
`define BLOB_ENGINE_DEFS_VH

// Format codes
`define FMT_NORMAL      2'h0
`define FMT_TEST        2'h1
`define FMT_MKV         2'h2
// Security state codes
`define SST_TRUSTED     2'h0
`define SST_SECURE      2'h1
`define SST_NONSECURE   2'h2
// Content codes: general data, or key blob with kek and mode selection
`define CNT_DATA        3'h0
`define CNT_KEY_JD_ECB  3'h4
`define CNT_KEY_JD_CCM  3'h5
`define CNT_KEY_TD_ECB  3'h6
`define CNT_KEY_TD_CCM  3'h7
// Layout of the blob in memory, in bytes
`define WRAPPED_KEY_LEN 16'h0020
`define MAC_LEN         16'h0010
`define KEY_BYTES_2     16'h0040
// Fixed nonce and initial counter shared by every blob
`define CCM_FIRST_BLOCK     128'h7A000000000000000000000000000000
`define CCM_INITIAL_COUNTER 128'h02000000000000000000000000000000
// Key sources for the derivation hash
`define KSRC_MASTER     1'h0
`define KSRC_TEST       1'h1
// Cipher modes
`define MODE_ECB        2'h0
`define MODE_CCM        2'h1
// Job status codes
`define ST_OK           4'h0
`define ST_BAD_FORMAT   4'h1
`define ST_MAC_FAIL     4'h2
`define ST_BAD_TYPE     4'h3

`endif

// file: blob_sub_model.sv
// Behavioural model of the rng, hash, cipher and memory writer units
`timescale 1ns/1ps
`default_nettype none
module blob_sub_model #(
    parameter logic [255:0] RNG_VAL = {8{32'h0BADC0DE}},
    parameter logic [255:0] KDF_VAL = {8{32'h5A5A1234}},
    parameter logic [255:0] ECB_VAL = {8{32'hB10B0001}},
    parameter logic [255:0] CCM_VAL = {8{32'h5E550002}}
) (
    // Clock, reset and scenario controls
    input  wire logic         core_clk_i, rst_n_i, slow_i, mac_bad_i,
    // Requests from the sequencer
    input  wire logic         rng_req_i, kdf_req_i, aes_req_i, wr_req_i,
    input  wire logic [1:0]   aes_mode_i,
    // Replies
    output logic              rng_ack_o, kdf_ack_o, aes_ack_o, wr_ack_o,
    output logic              aes_mac_ok_o,
    output logic [255:0]      rng_data_o, kdf_digest_o, aes_result_o
);
    logic [3:0]      req;
    logic [3:0]      ack;
    logic [3:0][2:0] cnt;
    assign req = {wr_req_i, aes_req_i, kdf_req_i, rng_req_i};
    assign {wr_ack_o, aes_ack_o, kdf_ack_o, rng_ack_o} = ack;
    // Ack lasts one cycle, then drops so two replies never merge
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack <= 4'h0;
            cnt <= '0;
        end else begin
            for (int u = 0; u < 4; u++) begin
                ack[u] <= 1'b0;
                cnt[u] <= 3'h0;
                if (req[u] && !ack[u]) begin
                    cnt[u] <= cnt[u] + 3'h1;
                    ack[u] <= (cnt[u] >= (slow_i ? 3'h5 : 3'h0));
                end
            end
        end
    end
    // Released lines carry the inverse, so a stale sample cannot match
    assign rng_data_o   = ack[0] ? RNG_VAL : ~RNG_VAL;
    assign kdf_digest_o = ack[1] ? KDF_VAL : ~KDF_VAL;
    assign aes_result_o = !ack[2] ? ~CCM_VAL :
                          (aes_mode_i == 2'h0) ? ECB_VAL : CCM_VAL;
    assign aes_mac_ok_o = ack[2] ? !mac_bad_i : mac_bad_i;
endmodule // blob_sub_model
`default_nettype wire

// file: blob_encap_decap_chk.sv
// Port-level assertions for the blob sequencer
`timescale 1ns/1ps
`default_nettype none
`include "blob_engine_defs.vh"
module blob_encap_decap_chk #(
    parameter int MOD_W = 128
) (
    input wire logic             core_clk_i, rst_n_i, job_valid_i, job_decap_i,
    input wire logic             job_ready_o, done_o, kdf_req_o, kdf_src_o,
    input wire logic             aes_req_o, aes_ack_i, aes_dec_o,
    input wire logic             aes_mac_ok_i, wr_req_o, key_load_o,
    input wire logic [1:0]       job_format_i, sec_state_i, aes_mode_o,
    input wire logic [2:0]       job_content_i,
    input wire logic [3:0]       status_o,
    input wire logic [MOD_W-1:0] job_modifier_i,
    input wire logic [MOD_W+4:0] kdf_msg_o,
    input wire logic [127:0]     ctx_first_block_o, ctx_initial_counter_o,
    input wire logic [31:0]      aes_len_o, job_len_i,
    input wire logic [31:0]      aes_offset_o, wr_offset_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic take;
    assign take = job_valid_i && job_ready_o;
    // Failed tag check on a CCM decrypt, of the payload or of the session key
    sequence mac_bad;
        aes_req_o && aes_ack_i && aes_mode_o == `MODE_CCM && aes_dec_o
            && !aes_mac_ok_i;
    endsequence
    chk_test_refused: assert property (take && job_format_i == `FMT_TEST
        && sec_state_i != `SST_NONSECURE |-> !(kdf_req_o || aes_req_o
        || wr_req_o) [*2] ##1 done_o && status_o == `ST_BAD_FORMAT)
        else $error("test format not refused");
    chk_bad_type: assert property (take && job_format_i == `FMT_NORMAL
        && job_content_i inside {3'h1, 3'h2, 3'h3}
        |-> ##2 done_o && status_o == `ST_BAD_TYPE)
        else $error("bad content code not refused");
    chk_ready_return: assert property (done_o |-> job_ready_o ##1 !done_o)
        else $error("ready not back after done");
    chk_kdf_source: assert property (kdf_req_o && job_format_i != `FMT_MKV
        |-> kdf_src_o == (sec_state_i == `SST_NONSECURE))
        else $error("wrong key source for state");
    chk_kdf_message: assert property (kdf_req_o |-> kdf_msg_o[1:0] ==
        sec_state_i && kdf_msg_o[MOD_W+4:5] == job_modifier_i)
        else $error("derivation message fields wrong");
    chk_ccm_context: assert property (aes_req_o && aes_mode_o == `MODE_CCM
        && (job_decap_i || !aes_dec_o)
        |-> ctx_first_block_o == `CCM_FIRST_BLOCK
        && ctx_initial_counter_o == `CCM_INITIAL_COUNTER
        && aes_len_o == job_len_i && aes_offset_o ==
        (job_format_i == `FMT_TEST ? 32'h00000060 : 32'h00000020))
        else $error("ccm context or offset wrong");
    chk_ecb_offset: assert property (aes_req_o && aes_mode_o == `MODE_ECB
        && (job_decap_i || !aes_dec_o) |-> aes_offset_o ==
        (job_format_i == `FMT_TEST ? 32'h00000040 : 32'h00000000))
        else $error("wrapped key not at blob start");
    chk_mac_status: assert property (mac_bad |-> ##[1:3]
        done_o && status_o == `ST_MAC_FAIL)
        else $error("mac failure not reported");
    chk_mac_noload: assert property (mac_bad |=> !key_load_o [*3])
        else $error("key loaded after mac failure");
    chk_load_ok: assert property (key_load_o |-> ##[0:2]
        done_o && status_o == `ST_OK)
        else $error("key load without good completion");
    chk_write_place: assert property (wr_req_o |-> wr_offset_o == 0 ||
        (job_format_i == `FMT_TEST && wr_offset_o == 32'h20))
        else $error("plain key written at wrong offset");
    cov_refused: cover property (done_o && status_o == `ST_BAD_FORMAT);
    cov_mac: cover property (mac_bad);
    cov_load: cover property (key_load_o);
endmodule // blob_encap_decap_chk
bind blob_encap_decap blob_encap_decap_chk #(.MOD_W(MOD_W)) chk (.*);
`default_nettype wire

// file: blob_encap_decap_tb_top.sv
// Self-checking testbench for the blob sequencer
`timescale 1ns/1ps
`default_nettype none
`include "blob_engine_defs.vh"
module blob_encap_decap_tb_top;
    localparam logic [255:0] CCM_VAL = {8{32'h5E550002}};
    logic core_clk_i, rst_n_i, job_valid_i, job_decap_i, job_to_key_reg_i;
    logic [1:0] job_format_i, sec_state_i;
    logic [2:0] job_content_i;
    logic [127:0] job_modifier_i;
    logic [31:0] job_len_i, trace;
    logic slow, mac_bad;
    logic [255:0] load_val;
    logic [2:0] kdf_type;
    logic [2:0] ty [5];
    int fail_count, cmp_count, loads, writes;
    wire job_ready_o, done_o, rng_req_o, rng_ack_i, kdf_req_o, kdf_src_o;
    wire kdf_ack_i, aes_req_o, aes_dec_o, aes_ack_i, aes_mac_ok_i;
    wire wr_req_o, wr_ack_i, key_load_o;
    wire [3:0] status_o;
    wire [1:0] aes_mode_o;
    wire [132:0] kdf_msg_o;
    wire [127:0] ctx_first_block_o, ctx_initial_counter_o;
    wire [31:0] aes_offset_o, aes_len_o, wr_offset_o;
    wire [255:0] rng_data_i, kdf_digest_i, aes_key_o, aes_result_i;
    wire [255:0] wr_data_o, key_load_data_o;
    blob_encap_decap #(.MOD_W(128)) dut (.*);
    blob_sub_model #(.CCM_VAL(CCM_VAL)) model (.core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i), .slow_i(slow), .mac_bad_i(mac_bad),
        .rng_req_i(rng_req_o), .kdf_req_i(kdf_req_o), .aes_req_i(aes_req_o),
        .wr_req_i(wr_req_o), .aes_mode_i(aes_mode_o), .rng_ack_o(rng_ack_i),
        .kdf_ack_o(kdf_ack_i), .aes_ack_o(aes_ack_i), .wr_ack_o(wr_ack_i),
        .aes_mac_ok_o(aes_mac_ok_i), .rng_data_o(rng_data_i),
        .kdf_digest_o(kdf_digest_i), .aes_result_o(aes_result_i));
    initial begin
        core_clk_i = 0;
        forever #4 core_clk_i = ~core_clk_i;
    end
    // Log each rng, hash and cipher reply as one nibble, so step order can be compared; writes are only counted
    // Logs restart at the edge that takes a job
    always @(posedge core_clk_i) begin
        if (job_valid_i && job_ready_o) {trace, loads, writes} <= '0;
        else if (rng_req_o && rng_ack_i) trace <= {trace[27:0], 4'h1};
        else if (aes_req_o && aes_ack_i)
            trace <= {trace[27:0], aes_mode_o == `MODE_CCM ? 4'h3 : 4'h4};
        else if (kdf_req_o && kdf_ack_i) begin
            trace <= {trace[27:0], 4'h2};
            kdf_type <= kdf_msg_o[4:2];
        end else if (wr_req_o && wr_ack_i) writes <= writes + 1;
        if (key_load_o) begin
            loads <= loads + 1;
            load_val <= key_load_data_o;
        end
    end
    task automatic check(input string what, input logic [255:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // One whole job: offer, wait for take, drop valid, wait for done
    task automatic run(input logic d, input logic [1:0] f, s,
                       input logic [2:0] c, input logic k);
        int n;
        while (job_ready_o !== 1'b1) @(posedge core_clk_i) #1;
        {job_decap_i, job_format_i, sec_state_i} = {d, f, s};
        {job_content_i, job_to_key_reg_i, job_valid_i} = {c, k, 1'b1};
        @(posedge core_clk_i) #1 job_valid_i = 0;
        for (n = 0; n < 400 && done_o !== 1'b1; n++) @(posedge core_clk_i) #1;
        check("done seen", done_o, 1'b1);
    endtask
    task automatic t_encap;
        for (int s = 0; s < 3; s++) begin
            slow = s[0];
            run(0, `FMT_NORMAL, s[1:0], `CNT_DATA, 0);
            check("encap status", status_o, `ST_OK);
            check("encap order", trace, 32'h1324);
        end
    endtask
    task automatic t_decap;
        run(1, `FMT_NORMAL, `SST_SECURE, `CNT_KEY_TD_CCM, 1);
        check("decap order", trace, 32'h243);
        check("key loads", loads, 1);
        check("key value", load_val, CCM_VAL);
        run(1, `FMT_NORMAL, `SST_TRUSTED, `CNT_DATA, 0);
        check("data decap loads", loads, 0);
        mac_bad = 1;
        run(1, `FMT_NORMAL, `SST_SECURE, `CNT_KEY_JD_ECB, 1);
        check("mac status", status_o, `ST_MAC_FAIL);
        check("mac loads", loads, 0);
        mac_bad = 0;
    endtask
    task automatic t_formats;
        for (int s = 0; s < 2; s++) begin
            run(s[0], `FMT_TEST, s[1:0], `CNT_DATA, 0);
            check("test refused", status_o, `ST_BAD_FORMAT);
            check("refused steps", trace, 0);
        end
        run(0, `FMT_TEST, `SST_NONSECURE, `CNT_DATA, 0);
        check("test status", status_o, `ST_OK);
        check("test writes", writes, 2);
        run(0, `FMT_MKV, `SST_TRUSTED, `CNT_DATA, 0);
        check("mkv writes", writes, 1);
        for (int c = 1; c < 4; c++) begin
            run(0, `FMT_NORMAL, `SST_SECURE, c[2:0], 0);
            check("type refused", status_o, `ST_BAD_TYPE);
        end
    endtask
    task automatic t_contents;
        for (int i = 0; i < 5; i++) begin
            run(0, `FMT_NORMAL, `SST_SECURE, i == 0 ? 3'h0 : 3'(i + 3), 0);
            check("content status", status_o, `ST_OK);
            check("content order", trace, i == 0 ? 32'h1324 :
                  (i[0] ? 32'h14324 : 32'h13324));
            ty[i] = kdf_type;
        end
        for (int i = 0; i < 5; i++)
            for (int j = i + 1; j < 5; j++)
                check("type codes differ", ty[i] == ty[j], 1'b0);
    endtask
    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        {rst_n_i, job_valid_i, job_decap_i, job_to_key_reg_i} = 4'h0;
        {job_format_i, sec_state_i, job_content_i} = 7'h00;
        job_modifier_i = 128'hC0FFEE0123456789ABCDEF0011223344;
        job_len_i = 32'h00000040;
        {slow, mac_bad} = 2'h0;
        repeat (20) @(posedge core_clk_i);
        #1 rst_n_i = 1;
        t_encap();
        t_decap();
        t_formats();
        t_contents();
        results();
    end
    // Watchdog well beyond the expected run length
    initial begin
        #(8 * 20000);
        fail_count++;
        results();
    end
endmodule // blob_encap_decap_tb_top
`default_nettype wire
